/* design/periph_disable.sv */
// Peripheral power-down control: disable registers, clock gates and held resets.
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps

// What this block does
// - Any reset clears all disable bits, so every peripheral starts enabled.
// - A set disable bit stops that peripheral's clock and control inputs.
// - A disabled peripheral is held in reset.
// - A disabled peripheral ignores register writes and reads back 0x00.
// - A disabled peripheral's analog outputs go off, digital outputs read zero.
// - Clearing a bit re-enables the peripheral from its power-on reset state.
// - A re-enabled peripheral may need one instruction cycle to become active.
// - First register bit 7 gates the system clock network to peripherals.
// - First register: bit6 vref, bit2 eeprom, bit1 clock out, bit0 pin change.
// - Eeprom unit off blocks eeprom access, control writes, indirect reads zero.
// - Second register: bit7 oscillator, bits 6..0 timers 6..0.
// - Third register: bit6 dac, bit5 adc, bits 2,1 comparators; others zero.
// - Fourth register: waveform gens, pulse units 6,5, capture/compare 4..1.
module periph_disable
  import periph_disable_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int REENABLE_CYCLES = 4
)
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Per-peripheral controls, index = register * 8 + bit.
  output logic [31:0] periph_clk_en,
  output logic [31:0] periph_rst,
  output logic [31:0] periph_isolate,
  // System clock network and eeprom unit controls.
  output logic periph_sysclk_en,
  output logic nvm_block,
  output logic nvm_ready
);

  localparam int CNT_W = 8;
  localparam int NVM_W = $clog2(NVM_WAKE_CYCLES + 1);
  localparam logic [CNT_W-1:0] REENABLE_LOAD = CNT_W'(REENABLE_CYCLES);
  localparam logic [NVM_W-1:0] NVM_LOAD = NVM_W'(NVM_WAKE_CYCLES);
  localparam logic [31:0] IMPL_MASK = {CTRL3_MASK, CTRL2_MASK, CTRL1_MASK, CTRL0_MASK};

  // The settle counters are eight bits wide; refuse what they cannot hold.
  if (REENABLE_CYCLES < 1 || REENABLE_CYCLES > 255)
  begin : g_bad_reenable
    $error("REENABLE_CYCLES must lie between 1 and 255");
  end
  if (ADDR_W < 5 || ADDR_W > 32)
  begin : g_bad_addr
    $error("ADDR_W must lie between 5 and 32");
  end

  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] dis;
    logic [31:0] clk_en;
    logic [31:0] rst;
    logic [31:0] iso;
    logic [31:0][CNT_W-1:0] settle;
    logic sysclk_en;
    logic nvm_block;
    logic [NVM_W-1:0] nvm_cnt;
    logic nvm_ready;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Address decode helpers.
  function automatic logic is_ctrl(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    o = 8'(a);
    is_ctrl = (a[ADDR_W-1:7] == '0) && (o == CTRL0_OFFS || o == CTRL1_OFFS ||
              o == CTRL2_OFFS || o == CTRL3_OFFS);
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = is_ctrl(a) || ((a[ADDR_W-1:7] == '0) && (8'(a) == READY_OFFS));
  endfunction

  // Next-state logic for the bus slave and the gating sequence.
  always_comb
  begin
    logic [31:0] dis_new;
    logic [1:0] idx;
    logic [CNT_W-1:0] cnt;
    dis_new = st_r.dis;
    idx = 2'h0;
    cnt = '0;
    st_nxt = st_r;

    // Write address and data are taken in either order and held.
    if (s_axi_awvalid && st_r.awready)
    begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready)
    begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata = s_axi_wdata[7:0];
      st_nxt.wstrb0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end

    // Perform the write once both halves are present and no response waits.
    if (st_r.aw_held && st_r.w_held && !st_r.bvalid)
    begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = is_mapped(st_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
      idx = st_r.awaddr[3:2];
      // Only the low byte lane carries register data; unused bits stay zero.
      if (is_ctrl(st_r.awaddr) && st_r.wstrb0)
      begin
        dis_new[idx*8 +: 8] = st_r.wdata & IMPL_MASK[idx*8 +: 8];
      end
    end
    st_nxt.dis = dis_new;
    // Ready signals stall a second half until the pending write is done.
    st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;

    // Read channel: one read in flight, answered the cycle after it is taken.
    if (s_axi_rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      st_nxt.rdata = 32'h0000_0000;
      if (is_ctrl(s_axi_araddr))
      begin
        st_nxt.rdata[7:0] = st_r.dis[s_axi_araddr[3:2]*8 +: 8];
      end
      else if (is_mapped(s_axi_araddr))
      begin
        st_nxt.rdata = ~st_r.iso;
      end
    end
    st_nxt.arready = !st_nxt.rvalid;

    // Per peripheral: clock follows the disable bit in the write cycle, the
    // reset lets go one cycle after the clock returns so the peripheral sees
    // at least one clocked reset edge, and isolation lifts after settling.
    for (int i = 0; i < 32; i++)
    begin
      st_nxt.clk_en[i] = !dis_new[i];
      st_nxt.rst[i] = dis_new[i] || !st_r.clk_en[i];
      if (dis_new[i])
      begin
        cnt = REENABLE_LOAD;
      end
      else if (st_r.settle[i] != '0)
      begin
        cnt = st_r.settle[i] - CNT_W'(1);
      end
      else
      begin
        cnt = '0;
      end
      st_nxt.settle[i] = cnt;
      // Isolation blocks writes, zeroes reads and outputs, turns analog off.
      // It keys on the registered count so it stands for the full settle time.
      st_nxt.iso[i] = dis_new[i] || (st_r.settle[i] != '0);
    end

    st_nxt.sysclk_en = !dis_new[PERIPH_SYSCLK_GATE_BIT];

    // Eeprom unit: block accesses while off, then wait out its wake time.
    st_nxt.nvm_block = dis_new[EEPROM_UNIT_OFF_BIT];
    if (dis_new[EEPROM_UNIT_OFF_BIT])
    begin
      st_nxt.nvm_cnt = NVM_LOAD;
    end
    else if (st_r.nvm_cnt != '0)
    begin
      st_nxt.nvm_cnt = st_r.nvm_cnt - NVM_W'(1);
    end
    // Ready waits one more edge after the count empties, so the full wake time passes.
    st_nxt.nvm_ready = !dis_new[EEPROM_UNIT_OFF_BIT] && (st_r.nvm_cnt == '0) &&
                       (st_nxt.nvm_cnt == '0);
  end

  // State register; reset leaves every peripheral enabled and running.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
      st_r.dis <= {CTRL_RESET, CTRL_RESET, CTRL_RESET, CTRL_RESET};
      st_r.clk_en <= '1;
      st_r.sysclk_en <= 1'b1;
      st_r.nvm_ready <= 1'b1;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Every output comes straight from the state register.
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign periph_clk_en = st_r.clk_en;
  assign periph_rst = st_r.rst;
  assign periph_isolate = st_r.iso;
  assign periph_sysclk_en = st_r.sysclk_en;
  assign nvm_block = st_r.nvm_block;
  assign nvm_ready = st_r.nvm_ready;

endmodule

/* inc/periph_disable_pkg.sv */
// Shared constants for the peripheral power-down control block.
package periph_disable_pkg;

  // Register byte offsets on the register bus.
  localparam logic [7:0] CTRL0_OFFS = 8'h00;
  localparam logic [7:0] CTRL1_OFFS = 8'h04;
  localparam logic [7:0] CTRL2_OFFS = 8'h08;
  localparam logic [7:0] CTRL3_OFFS = 8'h0C;
  localparam logic [7:0] READY_OFFS = 8'h10;

  // Reset value of every disable register.
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Writable bits of each disable register; others read zero.
  localparam logic [7:0] CTRL0_MASK = 8'hC7;
  localparam logic [7:0] CTRL1_MASK = 8'hFF;
  localparam logic [7:0] CTRL2_MASK = 8'h66;
  localparam logic [7:0] CTRL3_MASK = 8'hFF;

  // Field positions in the first disable register.
  localparam int PERIPH_SYSCLK_GATE_BIT = 7;
  localparam int VREF_OFF_BIT = 6;
  localparam int EEPROM_UNIT_OFF_BIT = 2;
  localparam int CLOCK_REF_OUT_OFF_BIT = 1;
  localparam int PIN_CHANGE_OFF_BIT = 0;
  // Field positions in the second register: timers occupy 6..0 in order.
  localparam int NUM_OSC_OFF_BIT = 7;
  // Field positions in the third register.
  localparam int DAC_UNIT_OFF_BIT = 6;
  localparam int ADC_UNIT_OFF_BIT = 5;
  localparam int COMPARATOR2_OFF_BIT = 2;
  localparam int COMPARATOR1_OFF_BIT = 1;
  // Fourth register: 7,6 waveform gens 2,1; 5,4 pulse units 6,5; 3..0 capcomp 4..1.
  localparam int WAVEFORM_GEN2_OFF_BIT = 7;
  localparam int CAPCOMP1_OFF_BIT = 0;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing: clock period and memory-unit wake time, both in ns.
  localparam int CLK_PERIOD_NS = 50;
  localparam int NVM_WAKE_NS = 1000;
  // Longest time, so round down, never below one cycle.
  localparam int NVM_WAKE_CYCLES = (NVM_WAKE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                   (NVM_WAKE_NS / CLK_PERIOD_NS);

endpackage

/* dv/periph_stub.sv */
// Behavioural timer peripheral fed by the gated clock, reset and isolation.
`timescale 1ns/100ps
module periph_stub
(
  // Controls from the block and the visible output.
  input wire logic aclk,
  input wire logic clk_en,
  input wire logic rst,
  input wire logic isolate,
  output logic [7:0] dout
);
  logic [7:0] cnt_r;
  // Counts only while clocked, so a stall shows as a frozen value.
  always_ff @(posedge aclk)
  begin
    if (rst)
      cnt_r <= 8'h00;
    else if (clk_en)
      cnt_r <= cnt_r + 8'h01;
  end
  // Outputs read zero while isolated.
  assign dout = isolate ? 8'h00 : cnt_r;
endmodule

/* dv/periph_disable_monitor.sv */
// Checker for the peripheral power-down control block.
`timescale 1ns/100ps
module periph_disable_monitor #(parameter int REENABLE_CYCLES = 4)
(
  // Clock, reset and bus handshakes.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripheral controls.
  input wire logic [31:0] periph_clk_en,
  input wire logic [31:0] periph_rst,
  input wire logic [31:0] periph_isolate,
  input wire logic periph_sysclk_en,
  input wire logic nvm_block,
  input wire logic nvm_ready
);
  localparam int ISO_GAP = REENABLE_CYCLES - 2;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A stopped clock or held reset never leaves outputs live.
  chk_gate_iso: assert property ((~periph_clk_en & ~periph_isolate) == 32'h0)
    else $error("clock stopped while outputs live");
  chk_rst_iso: assert property ((periph_rst & ~periph_isolate) == 32'h0)
    else $error("reset held while outputs live");
  chk_sysclk_map: assert property (periph_sysclk_en == periph_clk_en[7])
    else $error("system clock gate mismatch");
  chk_nvm_off: assert property (nvm_block |-> !nvm_ready && !periph_clk_en[2])
    else $error("memory unit live while blocked");
  chk_nvm_wake: assert property ($fell(nvm_block) |-> ##19 !nvm_ready ##1 nvm_ready)
    else $error("memory unit wake time wrong");
  // Reset drops one cycle after the clock returns, isolation later.
  chk_timer_wake: assert property ($rose(periph_clk_en[8]) |-> periph_rst[8] ##1
    !periph_rst[8] && periph_isolate[8] ##ISO_GAP periph_isolate[8] ##1 !periph_isolate[8])
    else $error("re-enable sequence wrong");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
  chk_busy_refuse: assert property (s_axi_bvalid || s_axi_rvalid |->
    !(s_axi_bvalid && s_axi_awready) && !(s_axi_rvalid && s_axi_arready))
    else $error("request taken while answer pending");
  cover property ($rose(periph_clk_en[8]));
  cover property ($fell(nvm_block));
  cover property ($fell(periph_sysclk_en));
  cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind periph_disable periph_disable_monitor #(.REENABLE_CYCLES(REENABLE_CYCLES)) u_mon (
  .aclk, .aresetn, .s_axi_awready, .s_axi_arready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rvalid, .s_axi_rready, .periph_clk_en, .periph_rst, .periph_isolate,
  .periph_sysclk_en, .nvm_block, .nvm_ready);

/* dv/testbench.sv */
// Self-checking bench for the peripheral power-down control block.
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench
  import periph_disable_pkg::*;
;
  localparam logic [31:0] MSK = {CTRL3_MASK, CTRL2_MASK, CTRL1_MASK, CTRL0_MASK};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic periph_sysclk_en, nvm_block, nvm_ready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, periph_clk_en, periph_rst, periph_isolate;
  logic [7:0] tmr_out;
  int fails = 0;
  int tests_run = 0;
  // Design, and one timer fed from its controls.
  periph_disable #(.REENABLE_CYCLES(4)) u_periph_disable (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periph_clk_en,
    .periph_rst, .periph_isolate, .periph_sysclk_en, .nvm_block, .nvm_ready);
  periph_stub u_periph_stub (.aclk, .clk_en(periph_clk_en[8]), .rst(periph_rst[8]),
    .isolate(periph_isolate[8]), .dout(tmr_out));
  always #25 aclk = ~aclk;
  // Write: address and data offered together, each released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    `CHK(s_axi_bresp, er)
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  // Read: one edge passes after the answer so ready is never reassigned at once.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    `CHK({s_axi_rresp, s_axi_rdata}, {er, e})
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic stop_test;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence.
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) rd(8'(i * 4), 32'h0, RESP_OKAY);
    `CHK({periph_clk_en, periph_rst, periph_isolate}, {32'hFFFFFFFF, 64'h0})
    `CHK({periph_sysclk_en, nvm_ready, nvm_block}, 3'b110)
    for (int i = 0; i < 4; i++) wr(8'(i * 4), 32'hFFFFFFFF, RESP_OKAY);
    for (int i = 0; i < 4; i++) rd(8'(i * 4), {24'h0, MSK[i*8 +: 8]}, RESP_OKAY);
    `CHK({periph_clk_en, periph_rst, periph_isolate}, {~MSK, MSK, MSK})
    `CHK({periph_sysclk_en, nvm_ready, nvm_block, tmr_out}, {3'b001, 8'h00})
    rd(READY_OFFS, ~MSK, RESP_OKAY);
    // No byte lane enabled, and an unmapped place, both leave the bits alone.
    s_axi_wstrb <= 4'h0;
    wr(CTRL1_OFFS, 32'h0, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    wr(8'h14, 32'h0, RESP_SLVERR);
    rd(8'h14, 32'h0, RESP_SLVERR);
    rd(CTRL1_OFFS, 32'hFF, RESP_OKAY);
    // Timers return from reset and stay isolated for the re-enable time.
    wr(CTRL1_OFFS, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK({periph_clk_en[15:8], periph_isolate[15:8]}, 16'hFFFF)
    @(posedge aclk);
    `CHK({periph_isolate[15:8], tmr_out < 8'h08}, 9'h001)
    wr(CTRL0_OFFS, 32'h0, RESP_OKAY);
    `CHK({nvm_block, periph_sysclk_en}, 2'b01)
    repeat (NVM_WAKE_CYCLES - 2) @(posedge aclk);
    `CHK(nvm_ready, 1'b0)
    @(posedge aclk);
    `CHK(nvm_ready, 1'b1)
    // A reset in mid-run clears every bit again.
    wr(CTRL3_OFFS, 32'hA5, RESP_OKAY);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(CTRL3_OFFS, 32'h0, RESP_OKAY);
    `CHK(periph_clk_en, 32'hFFFFFFFF)
    stop_test;
  end
  // Watchdog well beyond the hundred or so cycles the sequence needs.
  initial
  begin
    repeat (3000) @(posedge aclk);
    fails++;
    stop_test;
  end
endmodule
